// ==== fault_prot_pkg.sv ====
// Purpose: Constants shared by the regulator fault supervision logic
// Assumes: 40 MHz core clock; analog comparators deliver digital levels
// Notes: Times kept in printed units, cycle counts derived here
// Behaviour
// - Sample overcurrent comparator every 15 us, counting up or down.
// - Latch overcurrent fault when sample counter reaches eight.
// - Current above twice threshold latches overcurrent fault within 2 us.
// - Output 300 mV below ramped setpoint over 1 ms latches undervoltage.
// - Output 200 mV above ramped setpoint over 1 ms latches overvoltage.
// - Compare with instantaneous ramped setpoint, moving or settled.
// - Any ordinary fault forces power good low, and both gates low if no severe fault stands.
// - Ordinary faults hold until enable drops or supply reset occurs.
// - Severe overvoltage above 1.545 V raises fault immediately, unfiltered.
// - Severe fault: high gate and power good low, low gate until 0.77 V.
// - Severe fault keeps low gate toggling until supply reset only.
// - Severe fault detected even while another fault is latched.
// - No gate asserted until the opposite gate is below about 1 V.
// - Start-up selects unidirectional start-up ramp source.
// - After start-up use bidirectional dynamic ramp source, up or down.
// - Wait about 100 us after enable before starting setpoint ramp.
// - Power good released after output within 10% plus 6 switching cycles.
package fault_prot_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int OC_SAMPLE_NS = 15000;
  localparam int OC_SAMPLE_CYC = OC_SAMPLE_NS / (1000000000 / CLK_HZ);
  localparam int OC_TRIP_COUNT = 8;
  localparam int SHORT_MAX_NS = 2000;
  localparam int SHORT_FILT_CYC = 2;
  localparam int WIN_MS = 1;
  localparam int WIN_CYC = WIN_MS * (CLK_HZ / 1000);
  localparam int START_DELAY_US = 100;
  localparam int START_DELAY_CYC = START_DELAY_US * (CLK_HZ / 1000000);
  localparam int PG_SW_CYCLES = 6;
  localparam int SYNC_DEPTH = 2;
endpackage

// ==== power_stage_model.sv ====
// Purpose: Gate sense model of the external power stage
// Assumes: Gate inputs are the permissions driven by the supervisor
// Notes: Slow mode stretches gate discharge to four cycles
`timescale 1ns/100ps
module power_stage_model
(
  input wire logic clock_in,
  input wire logic slow_in,
  input wire logic high_gate_in,
  input wire logic low_gate_in,
  output logic high_gate_low_out,
  output logic low_gate_low_out
);
  logic [3:0] hi_hist_r = 4'h0;
  logic [3:0] lo_hist_r = 4'h0;
  logic slow_r = 1'b0;
  // Mode follows slow_in only while no gate is mid-discharge, so a sensed low never reverts
  always_ff @(posedge clock_in)
  begin
    if ((high_gate_in || hi_hist_r == 4'h0) && (low_gate_in || lo_hist_r == 4'h0))
      slow_r <= slow_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Gate charge history; a gate needs time to discharge
  always_ff @(posedge clock_in)
  begin
    hi_hist_r <= {hi_hist_r[2:0], high_gate_in};
    lo_hist_r <= {lo_hist_r[2:0], low_gate_in};
  end
  // Sensed below 1 V only after the gate stayed off long enough
  assign high_gate_low_out = !high_gate_in && (slow_r ? hi_hist_r == 4'h0 : !hi_hist_r[0]);
  assign low_gate_low_out = !low_gate_in && (slow_r ? lo_hist_r == 4'h0 : !lo_hist_r[0]);
endmodule

// ==== regulator_fault_protection.sv ====
// Purpose: Fault supervision, start sequencing and gate interlock
// Assumes: Comparator inputs asynchronous; rstn_in is the supply reset
// Notes: Gate outputs are permissions; the modulator supplies pwm demand
`timescale 1ns/100ps
module regulator_fault_protection
  import fault_prot_pkg::*;
#(
  parameter int UV_WIN_CYC = WIN_CYC,
  parameter int OV_WIN_CYC = WIN_CYC,
  parameter int START_CYC = START_DELAY_CYC
)
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic regulator_enable_input_in,
  input wire logic oc_over_in,
  input wire logic oc_short_in,
  input wire logic uv_below_soft_in,
  input wire logic ov_above_soft_in,
  input wire logic severe_ov_in,
  input wire logic severe_release_in,
  input wire logic high_gate_low_in,
  input wire logic low_gate_low_in,
  input wire logic pwm_high_in,
  input wire logic ramp_done_in,
  input wire logic in_window_in,
  input wire logic sw_cycle_in,
  input wire logic vid_up_in,
  output logic high_side_gate_out,
  output logic low_side_gate_out,
  output logic power_good_output_out,
  output logic startup_ramp_source_out,
  output logic dynamic_ramp_source_out,
  output logic ramp_discharge_out,
  output logic overcurrent_fault_out,
  output logic overvoltage_fault_out,
  output logic undervoltage_fault_out,
  output logic severe_fault_out
);
  typedef enum logic [2:0] {ST_OFF, ST_DELAY, ST_SOFT, ST_PGWAIT, ST_RUN, ST_FAULT} seq_e;

  // Phases in which the dynamic source owns the ramp node
  function automatic logic dyn_phase(input seq_e s);
    return (s == ST_PGWAIT || s == ST_RUN);
  endfunction

  initial
  begin
    if (UV_WIN_CYC < 1 || OV_WIN_CYC < 1 || START_CYC < 1)
      $error("Window and delay counts must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and filters
  logic en_s, oc_s, short_hit, uv_hit, ov_hit, sev_s, rel_s, hgl_s, lgl_s;
  logic pwm_s, done_s, win_s, swc_s, up_s, fault_clr;
  logic [5:0] raw_lvl;
  logic [5:0] sync_lvl;

  // Plain two-flop synchronisers for the level inputs
  assign raw_lvl = {low_gate_low_in, high_gate_low_in, severe_release_in, severe_ov_in,
    oc_over_in, regulator_enable_input_in};
  for (genvar g = 0; g < 6; g++)
  begin : g_sync
    sync_filter #(.LIMIT(1)) u_lvl (.clock_in(clock_in), .rstn_in(rstn_in),
      .level_in(raw_lvl[g]), .clear_in(1'b0), .sync_out(sync_lvl[g]), .hit_out());
  end
  assign {lgl_s, hgl_s, rel_s, sev_s, oc_s, en_s} = sync_lvl;
  // Short-circuit path: tiny filter keeps it far inside the 2 us budget
  sync_filter #(.LIMIT(SHORT_FILT_CYC)) u_sc (.clock_in(clock_in), .rstn_in(rstn_in),
    .level_in(oc_short_in), .clear_in(fault_clr), .sync_out(), .hit_out(short_hit));
  // UV/OV comparators reference the live soft node, not the target
  sync_filter #(.LIMIT(UV_WIN_CYC)) u_uv (.clock_in(clock_in), .rstn_in(rstn_in),
    .level_in(uv_below_soft_in), .clear_in(fault_clr), .sync_out(),
    .hit_out(uv_hit));
  sync_filter #(.LIMIT(OV_WIN_CYC)) u_ov (.clock_in(clock_in), .rstn_in(rstn_in),
    .level_in(ov_above_soft_in), .clear_in(fault_clr), .sync_out(),
    .hit_out(ov_hit));
  // Modulator-side signals share our clock, so no synchroniser
  assign pwm_s = pwm_high_in;
  assign done_s = ramp_done_in;
  assign win_s = in_window_in;
  assign swc_s = sw_cycle_in;
  assign up_s = vid_up_in;

  // Ordinary faults clear whenever enable is low
  assign fault_clr = !en_s;

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent sample timebase and up/down counter
  logic [$clog2(OC_SAMPLE_CYC)-1:0] tick_cnt_r;
  logic tick;
  logic [3:0] oc_cnt_r;
  assign tick = (tick_cnt_r == '0);

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || tick)
      tick_cnt_r <= ($clog2(OC_SAMPLE_CYC))'(OC_SAMPLE_CYC - 1);
    else
      tick_cnt_r <= tick_cnt_r - 1'b1;
  end

  // Saturates at zero; cleared with the fault reset
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || fault_clr)
      oc_cnt_r <= '0;
    else if (tick && oc_s && oc_cnt_r != 4'(OC_TRIP_COUNT))
      oc_cnt_r <= oc_cnt_r + 4'h1;
    else if (tick && !oc_s && oc_cnt_r != 4'h0)
      oc_cnt_r <= oc_cnt_r - 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ordinary fault latches
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || fault_clr)
      overcurrent_fault_out <= 1'b0;
    else if (oc_cnt_r == 4'(OC_TRIP_COUNT) || short_hit)
      overcurrent_fault_out <= 1'b1;
  end

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || fault_clr)
      undervoltage_fault_out <= 1'b0;
    else if (uv_hit)
      undervoltage_fault_out <= 1'b1;
  end

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || fault_clr)
      overvoltage_fault_out <= 1'b0;
    else if (ov_hit)
      overvoltage_fault_out <= 1'b1;
  end

  // Severe fault: only the supply reset clears it, regardless of other faults
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
      severe_fault_out <= 1'b0;
    else if (sev_s)
      severe_fault_out <= 1'b1;
  end

  logic any_fault;
  assign any_fault = overcurrent_fault_out | overvoltage_fault_out | undervoltage_fault_out;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequencer
  seq_e state_r;
  logic [$clog2(START_CYC+1)-1:0] dly_r;
  logic [2:0] pg_cnt_r;

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || !en_s)
      state_r <= ST_OFF;
    else
    begin
      case (state_r)
        ST_OFF: state_r <= ST_DELAY;
        ST_DELAY: if (dly_r == '0) state_r <= ST_SOFT;
        ST_SOFT: if (done_s) state_r <= ST_PGWAIT;
        ST_PGWAIT: if (pg_cnt_r == 3'(PG_SW_CYCLES)) state_r <= ST_RUN;
        ST_RUN: state_r <= ST_RUN;
        ST_FAULT: state_r <= ST_FAULT;
        default: state_r <= ST_OFF;
      endcase
      if (any_fault || severe_fault_out)
        state_r <= ST_FAULT;
    end
  end

  // Enable-to-ramp delay
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || state_r != ST_DELAY)
      dly_r <= ($clog2(START_CYC+1))'(START_CYC);
    else if (dly_r != '0)
      dly_r <= dly_r - 1'b1;
  end

  // Switching cycles counted only while inside the 10% window
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || state_r != ST_PGWAIT || !win_s)
      pg_cnt_r <= 3'h0;
    else if (swc_s && pg_cnt_r != 3'(PG_SW_CYCLES))
      pg_cnt_r <= pg_cnt_r + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp source selection
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      startup_ramp_source_out <= 1'b0;
      dynamic_ramp_source_out <= 1'b0;
      ramp_discharge_out <= 1'b0;
    end
    else
    begin
      startup_ramp_source_out <= (state_r == ST_SOFT);
      dynamic_ramp_source_out <= dyn_phase(state_r);
      ramp_discharge_out <= dyn_phase(state_r) && !up_s;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
      power_good_output_out <= 1'b0;
    else
      power_good_output_out <= (state_r == ST_RUN) && !any_fault && !severe_fault_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate drive with shoot-through interlock
  logic sev_low_on_r;
  localparam int OFF_W = $clog2(SYNC_DEPTH + 1);
  logic run_gate;
  logic [OFF_W-1:0] hi_off_r;
  logic [OFF_W-1:0] lo_off_r;
  logic hi_clear;
  logic lo_clear;
  assign run_gate = (state_r == ST_SOFT) || dyn_phase(state_r);

  // Sense trusted only after the synchroniser caught up; stale sense after a short pulse
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || high_side_gate_out)
      hi_off_r <= '0;
    else if (hi_off_r != OFF_W'(SYNC_DEPTH))
      hi_off_r <= hi_off_r + 1'b1;
  end
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || low_side_gate_out)
      lo_off_r <= '0;
    else if (lo_off_r != OFF_W'(SYNC_DEPTH))
      lo_off_r <= lo_off_r + 1'b1;
  end
  assign hi_clear = hgl_s && !high_side_gate_out && hi_off_r == OFF_W'(SYNC_DEPTH);
  assign lo_clear = lgl_s && !low_side_gate_out && lo_off_r == OFF_W'(SYNC_DEPTH);

  // Low gate hysteresis while severe fault stands
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
      sev_low_on_r <= 1'b0;
    else if (sev_s)
      sev_low_on_r <= 1'b1;
    else if (rel_s)
      sev_low_on_r <= 1'b0;
  end

  // Each gate waits for the sensed opposite gate to be low
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      high_side_gate_out <= 1'b0;
      low_side_gate_out <= 1'b0;
    end
    else if (severe_fault_out || sev_s)
    begin
      high_side_gate_out <= 1'b0;
      low_side_gate_out <= (sev_s || sev_low_on_r) && hi_clear;
    end
    else if (any_fault || !run_gate)
    begin
      high_side_gate_out <= 1'b0;
      low_side_gate_out <= 1'b0;
    end
    else
    begin
      high_side_gate_out <= pwm_s && lo_clear;
      low_side_gate_out <= !pwm_s && hi_clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_fault_gates_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(any_fault) && !severe_fault_out |=> !high_side_gate_out && !low_side_gate_out
    && !power_good_output_out)
    else $error("Gates or power good high after fault");
  a_fault_holds: assert property (@(posedge clock_in) disable iff (!rstn_in)
    overcurrent_fault_out && en_s |=> overcurrent_fault_out)
    else $error("Overcurrent fault dropped while enabled");
  a_oc_count_trip: assert property (@(posedge clock_in) disable iff (!rstn_in)
    oc_cnt_r == 4'(OC_TRIP_COUNT) && en_s |=> overcurrent_fault_out)
    else $error("Count of eight did not latch fault");
  a_oc_count_sat: assert property (@(posedge clock_in) disable iff (!rstn_in)
    oc_cnt_r == 4'h0 && !oc_s |=> oc_cnt_r == 4'h0)
    else $error("Counter went below zero");
  a_oc_tick_only: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !tick && en_s |=> $stable(oc_cnt_r))
    else $error("Counter moved off a sample tick");
  a_short_fast: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (oc_short_in && en_s) [*5] |=> overcurrent_fault_out)
    else $error("Short circuit not latched quickly");
  a_severe_sticky: assert property (@(posedge clock_in) disable iff (!rstn_in)
    severe_fault_out |=> severe_fault_out && !high_side_gate_out)
    else $error("Severe fault cleared or high gate on");
  a_severe_fast: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(sev_s) |=> severe_fault_out)
    else $error("Severe fault delayed");
  a_no_overlap: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !(high_side_gate_out && low_side_gate_out))
    else $error("Both gates on");
  a_ramp_select: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !(startup_ramp_source_out && dynamic_ramp_source_out))
    else $error("Both ramp sources selected");
  a_pg_late: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(power_good_output_out) |-> $past(state_r) == ST_RUN)
    else $error("Power good before count done");

  c_reach_run: cover property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(power_good_output_out));
  c_oc_trip: cover property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(overcurrent_fault_out));
  c_uv_trip: cover property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(undervoltage_fault_out));
  c_severe_toggle: cover property (@(posedge clock_in) disable iff (!rstn_in)
    severe_fault_out && $fell(low_side_gate_out));
endmodule

// ==== sync_filter.sv ====
// Purpose: Two-flop synchroniser with optional persistence filter
// Assumes: Input is an asynchronous comparator level
// Notes: Filtered output rises only after input held high for LIMIT cycles
`timescale 1ns/100ps
module sync_filter
  import fault_prot_pkg::*;
#(
  parameter int LIMIT = 1
)
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic level_in,
  input wire logic clear_in,
  output logic sync_out,
  output logic hit_out
);
  localparam int CW = $clog2(LIMIT + 1);
  logic [SYNC_DEPTH-1:0] stage_r;
  logic [CW-1:0] cnt_r;

  initial
  begin
    if (LIMIT < 1)
      $error("LIMIT must be at least one");
  end

  // Meta flop feeds only the second flop
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
      stage_r <= '0;
    else
      stage_r <= {stage_r[SYNC_DEPTH-2:0], level_in};
  end
  assign sync_out = stage_r[SYNC_DEPTH-1];

  // Continuous persistence count; any dropout restarts it
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || clear_in || !sync_out)
      cnt_r <= '0;
    else if (cnt_r != CW'(LIMIT))
      cnt_r <= cnt_r + 1'b1;
  end
  assign hit_out = (cnt_r == CW'(LIMIT));
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the fault supervisor
// Assumes: Short start delay and voltage windows via parameters
// Notes: Status changes are paired with queued notes of value and time
`timescale 1ns/100ps
module testbench
  import fault_prot_pkg::*;
;
  localparam int WIN = 20;
  localparam int SCYC = 10;
  typedef struct {logic [3:0] val; int lo; int hi;} note_s;
  note_s notes[$];
  note_s nt;
  logic clock_in = 1'b0;
  logic rstn_in, en, oc_over, oc_short, uv, ov, sev, rel, pwm, ramp_done;
  logic in_win, sw, vid_up, slow, high_gate, low_gate, power_good, ss_sel, dyn_sel, dis;
  logic ocf, ovf, uvf, svf, high_low, low_low, llow_prev;
  logic [3:0] stat_w, stat_prev;
  int cyc, mismatches, samples_checked, seed_v, n_hg;
  ////////////////////////////////////////////////////////////////////////////
  regulator_fault_protection #(.UV_WIN_CYC(WIN), .OV_WIN_CYC(WIN), .START_CYC(SCYC))
    i_regulator_fault_protection (.clock_in(clock_in), .rstn_in(rstn_in),
    .regulator_enable_input_in(en), .oc_over_in(oc_over), .oc_short_in(oc_short),
    .uv_below_soft_in(uv), .ov_above_soft_in(ov), .severe_ov_in(sev),
    .severe_release_in(rel), .high_gate_low_in(high_low), .low_gate_low_in(low_low),
    .pwm_high_in(pwm), .ramp_done_in(ramp_done), .in_window_in(in_win),
    .sw_cycle_in(sw), .vid_up_in(vid_up), .high_side_gate_out(high_gate),
    .low_side_gate_out(low_gate), .power_good_output_out(power_good),
    .startup_ramp_source_out(ss_sel), .dynamic_ramp_source_out(dyn_sel),
    .ramp_discharge_out(dis), .overcurrent_fault_out(ocf), .overvoltage_fault_out(ovf),
    .undervoltage_fault_out(uvf), .severe_fault_out(svf));
  power_stage_model i_power_stage_model (.clock_in(clock_in), .slow_in(slow),
    .high_gate_in(high_gate), .low_gate_in(low_gate), .high_gate_low_out(high_low),
    .low_gate_low_out(low_low));
  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock and cycle count
  initial
  begin
    forever #12.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) cyc <= cyc + 1;
  task automatic compare_status(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t status got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic compare_level(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t level got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic compare_time(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("ERROR %0t cycle got %h exp %h", $time, got, lo);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // Expected status and its earliest and latest cycle
  task automatic note(input logic [3:0] v, input int lo, input int hi);
    notes.push_back('{v, cyc + 1 + lo, cyc + 1 + hi});
  endtask
  task automatic start_up();
    ramp_done <= 1'b0;
    in_win <= 1'b0;
    en <= 1'b1;
    tick(SCYC);
    compare_level(10'({ss_sel, dyn_sel}), 10'h000);
    tick(10);
    compare_level(10'({ss_sel, dyn_sel}), 10'h002);
    ramp_done <= 1'b1;
    in_win <= 1'b1;
    repeat (PG_SW_CYCLES)
    begin
      tick(3);
      compare_level(10'(power_good), 10'h000);
      sw <= 1'b1;
      tick(1);
      sw <= 1'b0;
    end
    tick(4);
    compare_level(10'({power_good, ss_sel, dyn_sel}), 10'h005);
  endtask
  // Enable low clears ordinary faults; the system cycles it
  task automatic shut_down();
    en <= 1'b0;
    pwm <= 1'b0;
    tick(8);
  endtask
  task automatic results();
    if (notes.size() != 0)
      mismatches++;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watcher: every status change takes the oldest note; gates checked each cycle
  always @(negedge clock_in)
  begin
    stat_w = {svf, ocf, ovf, uvf};
    if (stat_w !== stat_prev)
    begin
      if (notes.size() == 0)
        compare_status(stat_w, stat_prev);
      else
      begin
        nt = notes.pop_front();
        compare_status(stat_w, nt.val);
        compare_time(cyc, nt.lo, nt.hi);
      end
    end
    stat_prev = stat_w;
    if (rstn_in)
      compare_level(10'(high_gate & (low_gate | !llow_prev)), 10'h000);
    llow_prev = low_low;
  end
  // Watchdog well beyond the planned run
  initial
  begin
    tick(60000);
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn_in, en, oc_over, oc_short, uv, ov, sev, rel, pwm, ramp_done} = 10'h000;
    {in_win, sw, vid_up, slow} = 4'h0;
    {cyc, mismatches, samples_checked, n_hg} = '0;
    stat_prev = 4'h0;
    llow_prev = 1'b1;
    seed_v = $urandom(32'hBFB9);
    tick(3);
    compare_level({high_gate, low_gate, power_good, ss_sel, dyn_sel, dis, ocf, ovf, uvf, svf},
      10'h000);
    rstn_in <= 1'b1;
    $display("test reset done");
    // Start-up, ramp direction, random pwm with prompt and slow gates
    start_up();
    vid_up <= 1'b0;
    tick(3);
    compare_level(10'(dis), 10'h001);
    vid_up <= 1'b1;
    tick(3);
    compare_level(10'(dis), 10'h000);
    repeat (40)
    begin
      pwm <= 1'($urandom);
      slow <= 1'($urandom);
      tick($urandom_range(12, 1));
      n_hg += int'(high_gate === 1'b1);
    end
    compare_level(10'(n_hg > 0), 10'h001);
    shut_down();
    $display("test start and interlock done");
    // Under and over voltage: glitch ignored, held level latches
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
      begin
        en <= 1'b1;
        tick(25);
      end
      else
        start_up();
      pwm <= 1'b1;
      {ov, uv} <= 2'(k + 1);
      tick(15);
      {ov, uv} <= 2'h0;
      tick(5);
      {ov, uv} <= 2'(k + 1);
      note(4'(k + 1), WIN + 1, WIN + 6);
      tick(WIN + 10);
      compare_level(10'({high_gate, low_gate, power_good}), 10'h000);
      {ov, uv} <= 2'h0;
      note(4'h0, 2, 6);
      shut_down();
    end
    $display("test voltage faults done");
    // Hard short
    start_up();
    oc_short <= 1'b1;
    note(4'h4, 3, 8);
    tick(12);
    compare_level(10'({high_gate, low_gate, power_good}), 10'h000);
    oc_short <= 1'b0;
    note(4'h0, 2, 6);
    shut_down();
    $display("test short done");
    // Counter up, down past zero, then a full trip
    start_up();
    oc_over <= 1'b1;
    tick(5 * OC_SAMPLE_CYC);
    oc_over <= 1'b0;
    tick(10 * OC_SAMPLE_CYC);
    oc_over <= 1'b1;
    note(4'h4, (OC_TRIP_COUNT - 1) * OC_SAMPLE_CYC, OC_TRIP_COUNT * OC_SAMPLE_CYC + 6);
    tick(OC_TRIP_COUNT * OC_SAMPLE_CYC + 10);
    oc_over <= 1'b0;
    note(4'h0, 2, 6);
    shut_down();
    $display("test overcurrent done");
    // Severe fault on top of a latched undervoltage
    start_up();
    uv <= 1'b1;
    note(4'h1, WIN + 1, WIN + 6);
    tick(WIN + 10);
    sev <= 1'b1;
    note(4'h9, 2, 4);
    tick(6);
    compare_level(10'({high_gate, power_good, low_gate}), 10'h001);
    sev <= 1'b0;
    rel <= 1'b1;
    tick(6);
    compare_level(10'(low_gate), 10'h000);
    rel <= 1'b0;
    sev <= 1'b1;
    tick(6);
    compare_level(10'(low_gate), 10'h001);
    sev <= 1'b0;
    rel <= 1'b1;
    uv <= 1'b0;
    note(4'h8, 2, 6);
    shut_down();
    rstn_in <= 1'b0;
    note(4'h0, 0, 2);
    tick(3);
    rstn_in <= 1'b1;
    rel <= 1'b0;
    tick(4);
    $display("test severe done");
    results();
  end
endmodule
